// ---- asc_bank.sv ----
// Alert status registers, software reset request and interface configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "asc_params.svh"

module asc_bank (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Register access from the command decoder
  input wire asc_pkg::asc_req_s req,
  output logic [15:0] rdata,
  output logic rvalid,
  // Interface select pin, high selects UART
  input wire logic interface_select,
  // Host path commands from the UART decoder
  input wire logic select_up_as_host_cmd,
  input wire logic select_down_as_host_cmd,
  // Alert enables from the threshold registers
  input wire asc_pkg::asc_cmp_s alert_enable,
  // ADC acquisition result
  input wire logic adc_acq_done,
  input wire logic [3:0] adc_aux_below,
  // Comparator acquisition result
  input wire logic cmp_acq_done,
  input wire asc_pkg::asc_cmp_s cmp_result,
  // Balance switch diagnostic result
  input wire logic bal_acq_done,
  input wire logic [2:0] scan_configuration,
  input wire logic [3:0] top_cell_position_one,
  input wire logic [13:0] bal_fail,
  // Software reset request and link controls
  output logic software_power_on_reset,
  output asc_pkg::asc_link_s link
);
  import asc_pkg::*;

  typedef struct packed {
    logic ifs_meta;
    logic ifs_sync;
    logic host_up;
    asc_cfg_s cfg;
    logic [3:0] aux_hot_alert_bits;
    logic [13:0] cmp_cell_high_bits;
    logic [13:0] cmp_cell_low_bits;
    logic [3:0] cmp_aux_cold_bits;
    logic [3:0] cmp_aux_hot_bits;
    logic [13:0] balance_switch_fault_bits;
    logic por_pulse;
    logic [15:0] rdata;
    logic rvalid;
    asc_link_s link;
  } asc_state_s;

  asc_state_s st;
  asc_state_s next_st;
  logic wr_cfg;
  logic wr_action;
  logic soft_por;
  logic spi_mode;
  logic [13:0] top_mask;
  logic [15:0] cfg_word;

  // Cells at or below the configured top position stay visible
  always_comb begin
    top_mask = 14'h0000;
    for (int i = 0; i < 14; i++) begin
      top_mask[i] = (4'(i) < top_cell_position_one);
    end
  end

  // Readback of the configuration word, host bit forced to one in SPI
  always_comb begin
    cfg_word = 16'h0000;
    cfg_word[`ASC_POS_TOPOLOGY +: 2] = st.cfg.uart_topology;
    cfg_word[`ASC_POS_UPPER_IDLE] = st.cfg.upper_tx_idle_float;
    cfg_word[`ASC_POS_LOWER_IDLE] = st.cfg.lower_tx_idle_float;
    cfg_word[`ASC_POS_ADAPTIVE +: 2] = st.cfg.adaptive_tx_select;
    cfg_word[`ASC_POS_ALIVE] = st.cfg.alive_counter_enable;
    cfg_word[`ASC_POS_HOST] = st.host_up | spi_mode;
    cfg_word[`ASC_POS_CSB_PULLUP] = st.cfg.chip_select_pullup_enable;
  end

  assign spi_mode = ~st.ifs_sync;
  assign wr_cfg = req.wr && (req.addr == `ASC_OFF_IF_CFG_ONE);
  assign wr_action = req.wr && (req.addr == `ASC_OFF_SW_ACTION);
  // only a written one starts the event
  assign soft_por = wr_action && req.wdata[`ASC_POS_SW_POR];

  // Next state of the whole bank
  always_comb begin
    next_st = st;
    // The pin is asynchronous, so only the second stage is ever used
    next_st.ifs_meta = interface_select;
    next_st.ifs_sync = st.ifs_meta;
    next_st.por_pulse = soft_por;

    // Soft reset clears alerts and the alive counter enable; acquisitions below win
    if (soft_por) begin
      next_st.aux_hot_alert_bits = 4'h0;
      next_st.cmp_cell_high_bits = 14'h0000;
      next_st.cmp_cell_low_bits = 14'h0000;
      next_st.cmp_aux_cold_bits = 4'h0;
      next_st.cmp_aux_hot_bits = 4'h0;
      next_st.balance_switch_fault_bits = 14'h0000;
      next_st.cfg.alive_counter_enable = 1'b0;
    end

    if (adc_acq_done) begin
      next_st.aux_hot_alert_bits = adc_aux_below & alert_enable.aux_hot;
    end
    if (cmp_acq_done) begin
      next_st.cmp_cell_high_bits = cmp_result.cell_high & alert_enable.cell_high;
      next_st.cmp_cell_low_bits = cmp_result.cell_low & alert_enable.cell_low;
      next_st.cmp_aux_cold_bits = cmp_result.aux_cold & alert_enable.aux_cold;
      next_st.cmp_aux_hot_bits = cmp_result.aux_hot & alert_enable.aux_hot;
    end
    if (bal_acq_done && scan_configuration[`ASC_SCAN_BAL_BIT]) begin
      next_st.balance_switch_fault_bits = bal_fail & top_mask;
    end

    // writable fields; soft reset clears only alive_counter_enable among them
    if (wr_cfg) begin
      next_st.cfg.uart_topology = req.wdata[`ASC_POS_TOPOLOGY +: 2];
      next_st.cfg.upper_tx_idle_float = req.wdata[`ASC_POS_UPPER_IDLE];
      next_st.cfg.lower_tx_idle_float = req.wdata[`ASC_POS_LOWER_IDLE];
      next_st.cfg.adaptive_tx_select = req.wdata[`ASC_POS_ADAPTIVE +: 2];
      next_st.cfg.alive_counter_enable = req.wdata[`ASC_POS_ALIVE];
      next_st.cfg.chip_select_pullup_enable = req.wdata[`ASC_POS_CSB_PULLUP];
    end

    // host path commands, down only reachable in dual mode
    if (select_up_as_host_cmd) begin
      next_st.host_up = 1'b1;
    end else if (select_down_as_host_cmd && (st.cfg.uart_topology == `ASC_TOPO_DUAL)) begin
      next_st.host_up = 1'b0;
    end
    if (next_st.cfg.uart_topology != `ASC_TOPO_DUAL) begin
      next_st.host_up = 1'b1;
    end

    // status registers have no write path; reads answer next cycle
    next_st.rvalid = req.rd;
    if (req.rd) begin
      case (req.addr)
        `ASC_OFF_AUX_HOT: next_st.rdata = {12'h000, st.aux_hot_alert_bits};
        `ASC_OFF_CMP_CELL_HIGH: next_st.rdata = {2'h0, st.cmp_cell_high_bits};
        `ASC_OFF_CMP_CELL_LOW: next_st.rdata = {2'h0, st.cmp_cell_low_bits};
        `ASC_OFF_CMP_AUX_COLD: next_st.rdata = {12'h000, st.cmp_aux_cold_bits};
        `ASC_OFF_CMP_AUX_HOT: next_st.rdata = {12'h000, st.cmp_aux_hot_bits};
        `ASC_OFF_BAL_SW: next_st.rdata = {2'h0, st.balance_switch_fault_bits};
        `ASC_OFF_SW_ACTION: next_st.rdata = 16'h0000;
        `ASC_OFF_IF_CFG_ONE: next_st.rdata = cfg_word;
        default: next_st.rdata = 16'h0000;
      endcase
    end

    // all UART controls but alive_counter_enable drop while SPI is selected, and host_path_flag is held at one
    next_st.link = '0;
    next_st.link.spi_mode = spi_mode;
    next_st.link.host_path_flag = st.host_up | spi_mode;
    next_st.link.alive_counter_enable = st.cfg.alive_counter_enable;
    next_st.link.csb_pullup_enable = spi_mode & st.cfg.chip_select_pullup_enable;
    if (!spi_mode) begin
      // up path always takes commands in from the lower side
      next_st.link.up_accepts_read = 1'b1;
      next_st.link.upper_tx_idle_float = st.cfg.upper_tx_idle_float;
      next_st.link.lower_tx_idle_float = st.cfg.lower_tx_idle_float;
      next_st.link.adapt_upper = (st.cfg.adaptive_tx_select == `ASC_ADAPT_UPPER);
      next_st.link.adapt_lower = (st.cfg.adaptive_tx_select == `ASC_ADAPT_LOWER);
      case (st.cfg.uart_topology)
        `ASC_TOPO_EXT_LOOP: begin
          next_st.link.up_accepts_write = 1'b1;
          next_st.link.down_is_return = 1'b1;
          next_st.link.se_alert_enable = 1'b1;
        end
        // internal shunt, engaged whenever internal loopback is selected
        `ASC_TOPO_INT_LOOP: begin
          next_st.link.up_accepts_write = 1'b1;
          next_st.link.down_is_return = 1'b1;
          next_st.link.se_alert_enable = 1'b1;
          next_st.link.loopback_shunt_en = 1'b1;
        end
        `ASC_TOPO_DIFF_ALERT: begin
          next_st.link.up_accepts_write = 1'b1;
          next_st.link.down_is_alert = 1'b1;
        end
        // writes only on the host path
        `ASC_TOPO_DUAL: begin
          next_st.link.up_accepts_write = st.host_up;
          next_st.link.down_accepts_write = ~st.host_up;
          next_st.link.down_accepts_read = 1'b1;
          next_st.link.se_alert_enable = 1'b1;
        end
        default: begin
          next_st.link.up_accepts_write = 1'b0;
        end
      endcase
    end
  end

  // State register; clock enable low freezes everything
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.host_up <= 1'b1;
      st.cfg.uart_topology <= `ASC_RST_TOPOLOGY;
      st.cfg.adaptive_tx_select <= `ASC_RST_ADAPTIVE;
      st.link.host_path_flag <= 1'b1;
      st.link.spi_mode <= 1'b1;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign rvalid = st.rvalid;
  assign software_power_on_reset = st.por_pulse;
  assign link = st.link;

  // pulse follows each written one by one cycle, back-to-back writes too
  property p_por_pulse;
    @(posedge core_clk) disable iff (!rstn)
      clk_en |=> (software_power_on_reset == $past(soft_por));
  endproperty
  a_por_pulse: assert property (p_por_pulse) else $error("soft reset pulse wrong");

  property p_action_reads_zero;
    @(posedge core_clk) disable iff (!rstn)
      (clk_en && req.rd && req.addr == `ASC_OFF_SW_ACTION) |=> (rvalid && rdata == 16'h0000);
  endproperty
  a_action_reads_zero: assert property (p_action_reads_zero) else $error("action reads nonzero");

  // cell high bits follow enabled results
  property p_cell_high;
    @(posedge core_clk) disable iff (!rstn)
      (clk_en && cmp_acq_done) |=>
        (st.cmp_cell_high_bits == $past(cmp_result.cell_high & alert_enable.cell_high));
  endproperty
  a_cell_high: assert property (p_cell_high) else $error("cell high alert mismatch");

  // cell low bits follow enabled results
  property p_cell_low;
    @(posedge core_clk) disable iff (!rstn)
      (clk_en && cmp_acq_done) |=>
        (st.cmp_cell_low_bits == $past(cmp_result.cell_low & alert_enable.cell_low));
  endproperty
  a_cell_low: assert property (p_cell_low) else $error("cell low alert mismatch");

  // no balance fault above the top cell
  property p_bal_mask;
    @(posedge core_clk) disable iff (!rstn)
      (clk_en && bal_acq_done && scan_configuration[2]) |=>
        ((st.balance_switch_fault_bits & ~$past(top_mask)) == 14'h0000);
  endproperty
  a_bal_mask: assert property (p_bal_mask) else $error("balance fault above top cell");

  // a write that is not a soft reset never changes the cell high or balance switch fault register
  property p_ro_write;
    @(posedge core_clk) disable iff (!rstn)
      (clk_en && req.wr && !adc_acq_done && !cmp_acq_done && !bal_acq_done && !soft_por)
        |=> $stable(st.cmp_cell_high_bits) && $stable(st.balance_switch_fault_bits);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("status changed by write");

  // dual mode never accepts writes on both paths
  property p_dual_write;
    @(posedge core_clk) disable iff (!rstn)
      !(link.up_accepts_write && link.down_accepts_write);
  endproperty
  a_dual_write: assert property (p_dual_write) else $error("writes on both paths");

  // SPI selection silences the UART controls one cycle on
  property p_spi_quiet;
    @(posedge core_clk) disable iff (!rstn)
      (clk_en && spi_mode) ##1 clk_en |->
        (!link.up_accepts_read && !link.loopback_shunt_en && !link.down_is_alert);
  endproperty
  a_spi_quiet: assert property (p_spi_quiet) else $error("UART active in SPI");

  // differential alert turns the single-ended alert off
  property p_diff_alert;
    @(posedge core_clk) disable iff (!rstn)
      link.down_is_alert |-> (!link.se_alert_enable && !link.down_is_return);
  endproperty
  a_diff_alert: assert property (p_diff_alert) else $error("alert paths both active");

  // host indicator reads one unless dual mode chose down
  property p_host_read;
    @(posedge core_clk) disable iff (!rstn)
      (clk_en && req.rd && req.addr == `ASC_OFF_IF_CFG_ONE && st.cfg.uart_topology != 2'h3)
        |=> rdata[8];
  endproperty
  a_host_read: assert property (p_host_read) else $error("host bit low outside dual");

  property p_topo_keep;
    @(posedge core_clk) disable iff (!rstn)
      (clk_en && soft_por && !wr_cfg) |=> $stable(st.cfg.uart_topology);
  endproperty
  a_topo_keep: assert property (p_topo_keep) else $error("topology lost on soft reset");

endmodule // asc_bank
`default_nettype wire

// ---- asc_params.svh ----
// Register map, field positions, reset values and codes of the alert and link configuration bank
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH

// Register offsets
`define ASC_OFF_AUX_HOT 8'h0d
`define ASC_OFF_CMP_CELL_HIGH 8'h0e
`define ASC_OFF_CMP_CELL_LOW 8'h0f
`define ASC_OFF_CMP_AUX_COLD 8'h10
`define ASC_OFF_CMP_AUX_HOT 8'h11
`define ASC_OFF_BAL_SW 8'h12
`define ASC_OFF_SW_ACTION 8'h13
`define ASC_OFF_IF_CFG_ONE 8'h14

// Field positions in the interface configuration and software action registers
`define ASC_POS_TOPOLOGY 14
`define ASC_POS_UPPER_IDLE 13
`define ASC_POS_LOWER_IDLE 12
`define ASC_POS_ADAPTIVE 10
`define ASC_POS_ALIVE 9
`define ASC_POS_HOST 8
`define ASC_POS_CSB_PULLUP 7
`define ASC_POS_SW_POR 0

// Reset values
`define ASC_RST_TOPOLOGY 2'h3
`define ASC_RST_ADAPTIVE 2'h0
`define ASC_RST_ALERT16 16'h0000

// Topology and adaptive codes
`define ASC_TOPO_EXT_LOOP 2'h0
`define ASC_TOPO_INT_LOOP 2'h1
`define ASC_TOPO_DIFF_ALERT 2'h2
`define ASC_TOPO_DUAL 2'h3
`define ASC_ADAPT_UPPER 2'h1
`define ASC_ADAPT_LOWER 2'h2

// Scan configuration codes 100..111 are balance switch diagnostics (top bit set)
`define ASC_SCAN_BAL_BIT 2

`endif

// ---- asc_pkg.sv ----
// Types of the alert status and interface configuration bank
package asc_pkg;

  // Comparator results and their per-channel enables share one layout
  typedef struct packed {
    logic [13:0] cell_high;
    logic [13:0] cell_low;
    logic [3:0] aux_cold;
    logic [3:0] aux_hot;
  } asc_cmp_s;

  // Register access request from the command decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } asc_req_s;

  // Stored configuration fields
  typedef struct packed {
    logic [1:0] uart_topology;
    logic upper_tx_idle_float;
    logic lower_tx_idle_float;
    logic [1:0] adaptive_tx_select;
    logic alive_counter_enable;
    logic chip_select_pullup_enable;
  } asc_cfg_s;

  // Effective link controls seen by the UART and pin logic
  typedef struct packed {
    logic spi_mode;
    logic up_accepts_write;
    logic up_accepts_read;
    logic down_accepts_write;
    logic down_accepts_read;
    logic down_is_return;
    logic down_is_alert;
    logic se_alert_enable;
    logic loopback_shunt_en;
    logic upper_tx_idle_float;
    logic lower_tx_idle_float;
    logic adapt_upper;
    logic adapt_lower;
    logic alive_counter_enable;
    logic csb_pullup_enable;
    logic host_path_flag;
  } asc_link_s;

endpackage

// ---- asc_host_model.sv ----
// Host model issuing register accesses to the alert and link configuration bank
`timescale 1ns/1ps
`default_nettype none

module asc_host_model (
  // Clock
  input wire logic core_clk,
  // Register port toward the bank
  output var asc_pkg::asc_req_s req,
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  import asc_pkg::*;

  // Idle bus at time zero
  initial begin
    req = '0;
  end

  // One-cycle write; released lines show inverted values so nothing stale looks valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // One-cycle read; answer is sampled at the edge after the taking edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(posedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h5a5a};
    @(posedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'ha5a5};
    @(posedge core_clk);
    d = rdata;
    v = rvalid;
  endtask
endmodule // asc_host_model
`default_nettype wire

// ---- tb_alert_status_and_link_config.sv ----
// Self-checking bench of the alert status and link configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "asc_params.svh"

module tb_alert_status_and_link_config;
  import asc_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic sel = 1'b1;
  logic up_cmd = 1'b0;
  logic dn_cmd = 1'b0;
  logic adc_done = 1'b0;
  logic cmp_done = 1'b0;
  logic bal_done = 1'b0;
  logic [3:0] below = 4'h0;
  logic [2:0] scan = 3'h0;
  logic [3:0] top = 4'h0;
  logic [13:0] fail = 14'h0;
  asc_cmp_s en = '0;
  asc_cmp_s res = '0;
  asc_req_s req;
  logic [15:0] rdata;
  logic rvalid;
  logic por;
  asc_link_s link;
  int err_total = 0;
  int comparisons = 0;
  // Expected state
  logic [1:0] topo = 2'h3;
  logic [1:0] adapt = 2'h0;
  logic uidle = 1'b0;
  logic lidle = 1'b0;
  logic alive = 1'b0;
  logic csb = 1'b0;
  logic host_up = 1'b1;
  asc_cmp_s a_cmp = '0;
  logic [3:0] a_adc = 4'h0;
  logic [13:0] a_bal = 14'h0;

  asc_bank u_dut (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .req(req),
    .rdata(rdata), .rvalid(rvalid), .interface_select(sel),
    .select_up_as_host_cmd(up_cmd), .select_down_as_host_cmd(dn_cmd),
    .alert_enable(en), .adc_acq_done(adc_done), .adc_aux_below(below),
    .cmp_acq_done(cmp_done), .cmp_result(res), .bal_acq_done(bal_done),
    .scan_configuration(scan), .top_cell_position_one(top), .bal_fail(fail),
    .software_power_on_reset(por), .link(link));

  asc_host_model u_host (.core_clk(core_clk), .req(req), .rdata(rdata), .rvalid(rvalid));

  // 10 MHz clock
  always #50 core_clk = ~core_clk;

  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic v;
    u_host.rd(a, d, v);
    chk({v, d}, {1'b1, e});
  endtask

  // Readback word of the configuration register; low bits are not built
  function automatic logic [15:0] cfg_word(input logic spi);
    return {topo, uidle, lidle, adapt, alive, host_up | spi, csb, 7'h0};
  endfunction

  // Effective link controls in UART mode, worked out from the stored fields
  function automatic asc_link_s exp_link();
    asc_link_s l;
    logic dual;
    dual = (topo == `ASC_TOPO_DUAL);
    l = '0;
    l.host_path_flag = host_up;
    l.up_accepts_write = !dual || host_up;
    l.up_accepts_read = 1'b1;
    l.down_accepts_write = dual && !host_up;
    l.down_accepts_read = dual;
    l.down_is_return = !topo[1];
    l.down_is_alert = (topo == `ASC_TOPO_DIFF_ALERT);
    l.se_alert_enable = (topo != `ASC_TOPO_DIFF_ALERT);
    l.loopback_shunt_en = (topo == `ASC_TOPO_INT_LOOP);
    l.upper_tx_idle_float = uidle;
    l.lower_tx_idle_float = lidle;
    l.adapt_upper = (adapt == `ASC_ADAPT_UPPER);
    l.adapt_lower = (adapt == `ASC_ADAPT_LOWER);
    l.alive_counter_enable = alive;
    return l;
  endfunction

  task automatic cfg_chk;
    @(posedge core_clk);
    #1;
    chk(17'(link), 17'(exp_link()));
    rchk(`ASC_OFF_IF_CFG_ONE, cfg_word(1'b0));
  endtask

  task automatic cfg_wr(input logic [15:0] d);
    u_host.wr(`ASC_OFF_IF_CFG_ONE, d);
    {topo, uidle, lidle, adapt, alive} = d[15:9];
    csb = d[7];
    if (topo != `ASC_TOPO_DUAL) host_up = 1'b1;
    cfg_chk;
  endtask

  task automatic host_cmd(input logic up);
    @(posedge core_clk);
    if (up) up_cmd <= 1'b1;
    else dn_cmd <= 1'b1;
    @(posedge core_clk);
    up_cmd <= 1'b0;
    dn_cmd <= 1'b0;
    if (up || topo == `ASC_TOPO_DUAL) host_up = up;
    cfg_chk;
  endtask

  task automatic rd_alerts;
    rchk(`ASC_OFF_AUX_HOT, {12'h0, a_adc});
    rchk(`ASC_OFF_CMP_CELL_HIGH, {2'h0, a_cmp.cell_high});
    rchk(`ASC_OFF_CMP_CELL_LOW, {2'h0, a_cmp.cell_low});
    rchk(`ASC_OFF_CMP_AUX_COLD, {12'h0, a_cmp.aux_cold});
    rchk(`ASC_OFF_CMP_AUX_HOT, {12'h0, a_cmp.aux_hot});
    rchk(`ASC_OFF_BAL_SW, {2'h0, a_bal});
  endtask

  // All three acquisitions end together; ADC and comparator results only count where enabled, balance faults up to the top cell
  task automatic acquire(input logic [2:0] s, input logic [3:0] tp);
    asc_cmp_s e;
    asc_cmp_s r;
    logic [3:0] b;
    logic [13:0] f;
    e = 36'({$urandom, $urandom});
    r = 36'({$urandom, $urandom});
    b = 4'($urandom);
    f = 14'($urandom);
    @(posedge core_clk);
    {en, res, below, scan, top, fail} <= {e, r, b, s, tp, f};
    {adc_done, cmp_done, bal_done} <= 3'h7;
    @(posedge core_clk);
    {adc_done, cmp_done, bal_done} <= 3'h0;
    a_cmp = r & e;
    a_adc = b & e.aux_hot;
    if (s[2]) a_bal = f & 14'((17'h1 << tp) - 17'h1);
    rd_alerts;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #3_000_000;
    err_total++;
    finish_test;
  end

  // Main sequence
  initial begin
    logic [15:0] d;
    void'($urandom(79));
    repeat (4) @(posedge core_clk);
    #1;
    chk(17'(link), 17'h08001);
    chk(17'({rvalid, por}), 17'h0);
    chk(17'(rdata), 17'h0);
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge core_clk);
    rd_alerts;
    rchk(`ASC_OFF_SW_ACTION, 16'h0);
    rchk(8'h20, 16'h0);
    cfg_chk;
    $display("test reset done");
    // every topology code is written twice here, and so is each adaptive code
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom);
      d[15:14] = 2'(i);
      d[11:10] = 2'(i >> 1);
      cfg_wr(d);
    end
    $display("test configuration done");
    acquire(3'h4, 4'h0);
    acquire(3'h7, 4'he);
    acquire(3'h3, 4'h5);
    repeat (20) acquire(3'($urandom), 4'($urandom));
    for (int a = 13; a <= 18; a++) begin
      u_host.wr(8'(a), 16'($urandom));
    end
    rd_alerts;
    $display("test alerts done");
    cfg_wr(16'hfe80);
    host_cmd(1'b0);
    sel <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    chk(17'({link.spi_mode, link.host_path_flag, link.csb_pullup_enable}), 17'(3'h7));
    rchk(`ASC_OFF_IF_CFG_ONE, cfg_word(1'b1));
    sel <= 1'b1;
    repeat (4) @(posedge core_clk);
    cfg_chk;
    // Clock enable low freezes the bank, so this write must not land
    clk_en <= 1'b0;
    u_host.wr(`ASC_OFF_IF_CFG_ONE, 16'h0000);
    clk_en <= 1'b1;
    cfg_chk;
    u_host.wr(`ASC_OFF_SW_ACTION, 16'hfffe);
    #1;
    chk(17'(por), 17'h0);
    u_host.wr(`ASC_OFF_SW_ACTION, 16'h0001);
    #1;
    chk(17'(por), 17'h1);
    @(posedge core_clk);
    #1;
    chk(17'(por), 17'h0);
    a_cmp = '0;
    a_adc = 4'h0;
    a_bal = 14'h0;
    alive = 1'b0;
    rd_alerts;
    cfg_chk;
    rchk(`ASC_OFF_SW_ACTION, 16'h0);
    host_cmd(1'b1);
    host_cmd(1'b0);
    cfg_wr(16'h3100);
    host_cmd(1'b0);
    $display("test host and soft reset done");
    finish_test;
  end
endmodule // tb_alert_status_and_link_config
`default_nettype wire
